// *** rtl/dsp_port.sv ***
`timescale 1ns/1ps
`include "dsp_map.svh"
module dsp_port (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    // Command pins
    input  wire logic                          command_clock,
    input  wire logic                          chip_select_n,
    input  wire logic                          write_cmd_n,
    input  wire logic                          refresh_cmd_n,
    input  wire logic [`DSP_BANK_W-1:0]        bank_select,
    input  wire logic [`DSP_ADDR_W-1:0]        address,
    // Write data pins
    input  wire logic                          write_data_clock,
    input  wire logic [`DSP_DATA_W-1:0]        write_data_in,
    input  wire logic                          write_data_mask,
    // Read data pins
    output logic [`DSP_DATA_W-1:0]             read_data_out,
    output logic                               read_data_clock,
    output logic                               read_valid_flag,
    // Core commit port and status
    output logic                               commit_valid,
    output logic [`DSP_BANK_W-1:0]             commit_bank,
    output logic [`DSP_ADDR_W-1:0]             commit_addr,
    output logic [`DSP_DATA_W-1:0]             commit_data,
    output logic [`DSP_ADDR_W-1:0]             config_word,
    output logic                               write_overrun,
    output logic                               busy
);
    import dsp_pkg::*;

    // ======================================================
    // Helpers
    // Beats per burst from the configuration field
    function automatic logic [3:0] beats_of(input logic [1:0] code);
        case (code)
            `DSP_BL_4: beats_of = 4'h4;
            `DSP_BL_8: beats_of = 4'h8;
            default:   beats_of = 4'h2;
        endcase
    endfunction

    // Column bits kept: log2 of the span of eight divided by the burst
    function automatic logic [1:0] col_bits(input logic [1:0] code);
        case (code)
            `DSP_BL_4: col_bits = 2'h1;
            `DSP_BL_8: col_bits = 2'h0;
            default:   col_bits = `DSP_COL_MAX;
        endcase
    endfunction

    // ======================================================
    // Input synchronisers
    localparam int BW = $bits(dsp_beat_t);

    dsp_cmd_t  cmd_s1;
    dsp_cmd_t  cmd_s2;
    dsp_beat_t beat_s1;
    dsp_beat_t beat_s2;
    logic      ck_s1;
    logic      ck_s2;
    logic      ck_d;
    logic      dk_s1;
    logic      dk_s2;
    logic      dk_d;

    // Every pin passes two flops; data and clocks share the delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_s1  <= '0;
            cmd_s2  <= '0;
            beat_s1 <= '0;
            beat_s2 <= '0;
            ck_s1   <= 1'b0;
            ck_s2   <= 1'b0;
            ck_d    <= 1'b0;
            dk_s1   <= 1'b0;
            dk_s2   <= 1'b0;
            dk_d    <= 1'b0;
        end else begin
            cmd_s1  <= {chip_select_n, write_cmd_n, refresh_cmd_n,
                        bank_select, address};
            cmd_s2  <= cmd_s1;
            beat_s1 <= {write_data_mask, write_data_in};
            beat_s2 <= beat_s1;
            ck_s1   <= command_clock;
            ck_s2   <= ck_s1;
            ck_d    <= ck_s2;
            dk_s1   <= write_data_clock;
            dk_s2   <= dk_s1;
            dk_d    <= dk_s2;
        end
    end

    logic ck_rise;
    logic dk_edge;
    assign ck_rise = ck_s2 && !ck_d;
    assign dk_edge = dk_s2 ^ dk_d;

    // ======================================================
    // Write beat buffer
    dsp_beat_t fifo_out;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    logic      fifo_out_ready;

    // Both edges push one word with its own mask
    dsp_fifo #(
        .WIDTH (BW),
        .DEPTH (`DSP_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (dk_edge),
        .in_ready  (fifo_in_ready),
        .in_data   (beat_s2),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    // Pins cannot be stalled, so a beat lost to a full buffer is flagged
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            write_overrun <= 1'b0;
        end else if (dk_edge && !fifo_in_ready) begin
            write_overrun <= 1'b1;
        end
    end

    // ======================================================
    // Command decode and operation control
    dsp_state_t                state;
    logic [3:0]                beat_cnt;
    logic [3:0]                beats;
    logic [`DSP_BANK_W-1:0]    op_bank;
    logic [`DSP_ADDR_W-1:0]    op_addr;
    logic                      take;
    logic                      qk_tick;
    logic [`DSP_DATA_W-1:0]    bank_word [`DSP_BANKS];

    // New commands only in idle; chip select gates the decoder
    assign take = ck_rise && !cmd_s2.cs_n && (state == DSP_IDLE);
    assign beats = beats_of(config_word[`DSP_BL_HI:`DSP_BL_LO]);
    assign fifo_out_ready = (state == DSP_WRITE);

    // Column mask keeps the low col_bits bits of address bits 1:0 and clears the rest of them
    function automatic logic [`DSP_ADDR_W-1:0] col_mask(
        input logic [`DSP_ADDR_W-1:0] a, input logic [1:0] code);
        logic [`DSP_ADDR_W-1:0] m;
        m = '1;
        m[1:0] = 2'h0;
        case (col_bits(code))
            2'h2:    m[1:0] = 2'h3;
            2'h1:    m[0]   = 1'b1;
            default: m[1:0] = 2'h0;
        endcase
        col_mask = a & m;
    endfunction

    // State sequence; chip select plays no part once running
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= DSP_IDLE;
            beat_cnt <= 4'h0;
            op_bank  <= '0;
            op_addr  <= '0;
        end else begin
            case (state)
                DSP_IDLE: begin
                    beat_cnt <= 4'h0;
                    if (take) begin
                        op_bank <= cmd_s2.bank;
                        op_addr <= col_mask(cmd_s2.addr,
                            config_word[`DSP_BL_HI:`DSP_BL_LO]);
                        if (!cmd_s2.we_n && !cmd_s2.ref_n) begin
                            state <= DSP_IDLE;
                        end else if (!cmd_s2.we_n) begin
                            state <= DSP_WRITE;
                        end else if (!cmd_s2.ref_n) begin
                            state <= DSP_REFRESH;
                        end else begin
                            state <= DSP_READ;
                        end
                    end
                end
                DSP_WRITE: begin
                    if (fifo_out_valid) begin
                        beat_cnt <= beat_cnt + 4'h1;
                        if (beat_cnt == beats - 4'h1) begin
                            state <= DSP_IDLE;
                        end
                    end
                end
                DSP_READ: begin
                    if (qk_tick) begin
                        beat_cnt <= beat_cnt + 4'h1;
                        if (beat_cnt == beats - 4'h1) begin
                            state <= DSP_IDLE;
                        end
                    end
                end
                DSP_REFRESH: begin
                    beat_cnt <= beat_cnt + 4'h1;
                    if (beat_cnt == 4'(`DSP_REF_CYC - 1)) begin
                        state <= DSP_IDLE;
                    end
                end
                default: state <= DSP_IDLE;
            endcase
        end
    end

    // Configuration load takes the whole address bus
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            config_word <= `DSP_CFG_RESET;
        end else if (take && !cmd_s2.we_n && !cmd_s2.ref_n) begin
            config_word <= cmd_s2.addr;
        end
    end

    // Busy shows an operation in progress
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != DSP_IDLE);
        end
    end

    // ======================================================
    // Write commit
    // Masked beats still advance the burst but change nothing
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            commit_valid <= 1'b0;
            commit_bank  <= '0;
            commit_addr  <= '0;
            commit_data  <= '0;
            for (int i = 0; i < `DSP_BANKS; i++) begin
                bank_word[i] <= '0;
            end
        end else begin
            commit_valid <= 1'b0;
            if (state == DSP_WRITE && fifo_out_valid &&
                !fifo_out.mask) begin
                commit_valid       <= 1'b1;
                commit_bank        <= op_bank;
                commit_addr        <= op_addr | `DSP_ADDR_W'(beat_cnt);
                commit_data        <= fifo_out.data;
                bank_word[op_bank] <= fifo_out.data;
            end
        end
    end

    // ======================================================
    // Read clock divider and read beats
    logic [3:0] qk_cnt;
    assign qk_tick = (qk_cnt == 4'(`DSP_QK_HALF - 1));

    // Free-running read clock toggles every half period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            qk_cnt          <= 4'h0;
            read_data_clock <= 1'b0;
        end else if (qk_tick) begin
            qk_cnt          <= 4'h0;
            read_data_clock <= !read_data_clock;
        end else begin
            qk_cnt <= qk_cnt + 4'h1;
        end
    end

    // Data and valid change on the same cycle as the clock edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            read_data_out   <= '0;
            read_valid_flag <= 1'b0;
        end else if (qk_tick) begin
            if (state == DSP_READ) begin
                read_data_out   <= bank_word[op_bank];
                read_valid_flag <= 1'b1;
            end else begin
                read_valid_flag <= 1'b0;
            end
        end
    end
endmodule

// *** rtl/dsp_map.svh ***
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH
// ==========================================================
// Widths
`define DSP_ADDR_W      20
`define DSP_BANK_W      3
`define DSP_DATA_W      18
`define DSP_BANKS       8
`define DSP_FIFO_DEPTH  16
// ==========================================================
// Configuration word layout and reset value
`define DSP_CFG_RESET   20'h00000
`define DSP_BL_LO       0
`define DSP_BL_HI       1
`define DSP_BL_2        2'h0
`define DSP_BL_4        2'h1
`define DSP_BL_8        2'h2
// Burst times column span is always this many beats
`define DSP_SPAN        4'h8
`define DSP_COL_MAX     2'h2
// ==========================================================
// Timing
`define DSP_CLK_NS      5
`define DSP_TREF_NS     15
`define DSP_REF_CYC     ((`DSP_TREF_NS + `DSP_CLK_NS - 1) / `DSP_CLK_NS)
`define DSP_TQK_NS      80
`define DSP_QK_HALF     ((`DSP_TQK_NS / 2) / `DSP_CLK_NS)
`endif

// *** rtl/dsp_pkg.sv ***
`include "dsp_map.svh"
package dsp_pkg;
    // ======================================================
    // Command as sampled at a command clock rising edge
    typedef struct packed {
        logic                    cs_n;
        logic                    we_n;
        logic                    ref_n;
        logic [`DSP_BANK_W-1:0]  bank;
        logic [`DSP_ADDR_W-1:0]  addr;
    } dsp_cmd_t;

    // One write beat: mask above data
    typedef struct packed {
        logic                    mask;
        logic [`DSP_DATA_W-1:0]  data;
    } dsp_beat_t;

    // Internal operation in progress
    typedef enum logic [3:0] {
        DSP_IDLE    = 4'h1,
        DSP_WRITE   = 4'h2,
        DSP_READ    = 4'h4,
        DSP_REFRESH = 4'h8
    } dsp_state_t;
endpackage

// *** rtl/dsp_fifo.sv ***
`timescale 1ns/1ps
// ==========================================================
// Write beat buffer with registered read data
module dsp_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Output register counts as one of the DEPTH words, so no more
    // than DEPTH words are ever held in total
    assign in_ready = ((count + {{AW{1'b0}}, out_valid}) != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    assign pop      = (count != '0) && (!out_valid || out_ready);

    // Storage array
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    // Output register keeps read data off the array's mux path
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// *** test/dsp_port_checker.sv ***
`timescale 1ns/1ps
`include "dsp_map.svh"
// ==========================================================
// Port checks for the input port
module dsp_port_checker (
    // Clock and reset
    input wire logic                   mclk,
    input wire logic                   reset_n,
    // Command and write pins
    input wire logic                   command_clock,
    input wire logic                   chip_select_n,
    input wire logic                   write_cmd_n,
    input wire logic                   refresh_cmd_n,
    input wire logic [`DSP_ADDR_W-1:0] address,
    input wire logic                   write_data_clock,
    // Outputs
    input wire logic [`DSP_DATA_W-1:0] read_data_out,
    input wire logic                   read_data_clock,
    input wire logic                   read_valid_flag,
    input wire logic [`DSP_ADDR_W-1:0] config_word,
    input wire logic                   write_overrun,
    input wire logic                   busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Work starts only after a synced command clock rise with select low
    chk_busy_edge: assert property (
        $rose(busy) |-> $past(command_clock, 2) && !$past(command_clock, 6))
        else $error("busy rose without a command clock rise");
    chk_busy_select: assert property (
        $rose(busy) |-> !$past(chip_select_n, 2))
        else $error("busy rose while chip select was high");
    // Config word moves only on a selected load, and copies the address
    chk_cfg_source: assert property (
        $changed(config_word) |-> $past(command_clock, 2)
            && !$past(chip_select_n, 2) && !$past(write_cmd_n, 2)
            && !$past(refresh_cmd_n, 2))
        else $error("config word changed without a load command");
    chk_cfg_value: assert property (
        $changed(config_word) |-> config_word == $past(address, 2))
        else $error("config word differs from the address lines");
    // Read side: valid and data move with the read clock only
    chk_read_align: assert property (
        $changed(read_valid_flag) |-> $changed(read_data_clock))
        else $error("read valid moved off a read clock toggle");
    chk_read_period: assert property (
        $rose(read_data_clock) |=> read_data_clock[*7] ##1 !read_data_clock)
        else $error("read clock high phase is not 8 cycles");
    chk_read_data: assert property (
        $changed(read_data_out) |-> $changed(read_data_clock))
        else $error("read data moved off a read clock toggle");
    // Overrun is sticky and only appears right after a write clock edge
    chk_overrun_keep: assert property (
        write_overrun |=> write_overrun)
        else $error("overrun flag cleared without reset");
    chk_overrun_cause: assert property (
        $rose(write_overrun)
            |-> $past(write_data_clock, 2) != $past(write_data_clock, 6))
        else $error("overrun rose away from a write clock edge");
endmodule
bind dsp_port dsp_port_checker u_dsp_port_checker (
    .mclk(mclk), .reset_n(reset_n), .command_clock(command_clock),
    .chip_select_n(chip_select_n), .write_cmd_n(write_cmd_n),
    .refresh_cmd_n(refresh_cmd_n), .address(address),
    .write_data_clock(write_data_clock), .read_data_out(read_data_out),
    .read_data_clock(read_data_clock), .read_valid_flag(read_valid_flag),
    .config_word(config_word), .write_overrun(write_overrun), .busy(busy)
);

// *** test/dsp_ctrl_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Controller model: commands and write beats, clocks idle between
module dsp_ctrl_model (
    // Clock
    input  wire logic          mclk,
    // Command side
    output logic               command_clock,
    output dsp_pkg::dsp_cmd_t  cmd,
    // Write data side
    output logic               write_data_clock,
    output dsp_pkg::dsp_beat_t beat
);
    import dsp_pkg::*;
    // Deselected and quiet at time zero
    initial begin
        command_clock = 1'b0;
        write_data_clock = 1'b0;
        cmd = '1;
        beat = '0;
    end
    // Lines settle 8 cycles before the rise and hold 8 after the fall,
    // so a synced rise can never see a half-changed command
    task automatic issue(input dsp_cmd_t c);
        @(posedge mclk);
        #1 cmd = c;
        repeat (8) @(posedge mclk);
        #1 command_clock = 1'b1;
        repeat (8) @(posedge mclk);
        #1 command_clock = 1'b0;
        repeat (8) @(posedge mclk);
        #1 cmd = ~c;
    endtask
    // One beat per write clock edge, 40 ns apart; old data is not kept
    task automatic send_beat(input dsp_beat_t b);
        @(posedge mclk);
        #1 beat = b;
        repeat (3) @(posedge mclk);
        #1 write_data_clock = ~write_data_clock;
        repeat (4) @(posedge mclk);
        #1 beat = ~b;
    endtask
endmodule

// *** test/tb_dsp_port.sv ***
`timescale 1ns/1ps
`include "dsp_map.svh"
// ==========================================================
// Bench for the input port
module tb_dsp_port;
    import dsp_pkg::*;
    logic                   mclk;
    logic                   reset_n;
    logic                   command_clock;
    logic                   write_data_clock;
    dsp_cmd_t               cmd;
    dsp_beat_t              beat;
    logic [`DSP_DATA_W-1:0] read_data_out;
    logic                   read_data_clock;
    logic                   read_valid_flag;
    logic                   commit_valid;
    logic [`DSP_BANK_W-1:0] commit_bank;
    logic [`DSP_ADDR_W-1:0] commit_addr;
    logic [`DSP_DATA_W-1:0] commit_data;
    logic [`DSP_ADDR_W-1:0] config_word;
    logic                   write_overrun;
    logic                   busy;
    int                     error_cnt = 0;
    int                     cmp_count = 0;
    int                     commit_cnt = 0;
    int                     busy_cnt = 0;
    int                     commit_base = 0;
    int                     busy_base = 0;
    logic [`DSP_ADDR_W-1:0] first_addr;
    logic [`DSP_DATA_W-1:0] first_data;
    logic [`DSP_BANK_W-1:0] first_bank;
    logic [`DSP_DATA_W-1:0] last_read;
    // 200 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    dsp_ctrl_model u_dsp_ctrl_model (
        .mclk(mclk), .command_clock(command_clock), .cmd(cmd),
        .write_data_clock(write_data_clock), .beat(beat)
    );
    dsp_port u_dsp_port (
        .mclk(mclk), .reset_n(reset_n), .command_clock(command_clock),
        .chip_select_n(cmd.cs_n), .write_cmd_n(cmd.we_n),
        .refresh_cmd_n(cmd.ref_n), .bank_select(cmd.bank),
        .address(cmd.addr), .write_data_clock(write_data_clock),
        .write_data_in(beat.data), .write_data_mask(beat.mask),
        .read_data_out(read_data_out), .read_data_clock(read_data_clock),
        .read_valid_flag(read_valid_flag), .commit_valid(commit_valid),
        .commit_bank(commit_bank), .commit_addr(commit_addr),
        .commit_data(commit_data), .config_word(config_word),
        .write_overrun(write_overrun), .busy(busy)
    );
    // Recorders: commits and read beats can pass while a task is blocked
    always @(posedge mclk) begin
        if (commit_valid === 1'b1 && commit_cnt == commit_base) begin
            first_addr <= commit_addr;
            first_data <= commit_data;
            first_bank <= commit_bank;
        end
        if (commit_valid === 1'b1) begin
            commit_cnt <= commit_cnt + 1;
        end
        if (busy === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
        if (read_valid_flag === 1'b1) begin
            last_read <= read_data_out;
        end
    end
    // ======================================================
    // Shared tasks
    task automatic check(input string name, input logic [19:0] seen,
                         input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 400) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    // Op is {select_n, write_n, refresh_n}
    function automatic dsp_cmd_t mk(input logic [2:0] op,
                                    input logic [2:0] b,
                                    input logic [19:0] a);
        return {op, b, a};
    endfunction
    // ======================================================
    // Scenarios
    task automatic t_deselect;
        u_dsp_ctrl_model.issue(mk(3'h4, 3'h0, 20'h5A4C1));
        check("deselected load", config_word, 20'h00000);
        check("deselected busy", {19'h0, busy}, 20'h00000);
    endtask
    // Load burst length, write beats after the command, read back
    task automatic t_burst(input logic [1:0] code);
        int                     bl;
        logic [`DSP_ADDR_W-1:0] a;
        bl = 2 << code;
        a = 20'h0F0F3;
        u_dsp_ctrl_model.issue(mk(3'h0, 3'h0, {18'h0, code}));
        check("config_word", config_word, {18'h0, code});
        commit_base = commit_cnt;
        u_dsp_ctrl_model.issue(mk(3'h1, {1'b1, code}, a));
        for (int i = 1; i <= bl; i++) begin
            u_dsp_ctrl_model.send_beat({1'b0, 18'(i * 256 + code)});
        end
        wait_idle();
        check("commits", 20'(commit_cnt - commit_base), 20'(bl));
        check("bank", {17'h0, first_bank}, {17'h0, 1'b1, code});
        check("addr", first_addr, {a[19:2], code == 2'h0 ? a[1:0] :
              code == 2'h1 ? 2'h1 : 2'h0});
        check("data", {2'h0, first_data}, 20'(256 + code));
        u_dsp_ctrl_model.issue(mk(3'h3, {1'b1, code}, a));
        wait_idle();
        check("read", {2'h0, last_read}, 20'(bl * 256 + code));
    endtask
    // Beats queued first; odd beats masked keep their slot only
    task automatic t_masked;
        commit_base = commit_cnt;
        for (int i = 0; i < 8; i++) begin
            u_dsp_ctrl_model.send_beat({i[0], 18'(i + 18'h00040)});
        end
        u_dsp_ctrl_model.issue(mk(3'h1, 3'h7, 20'h00000));
        wait_idle();
        check("masked commits", 20'(commit_cnt - commit_base), 20'h00004);
        u_dsp_ctrl_model.issue(mk(3'h3, 3'h7, 20'h00000));
        wait_idle();
        check("masked read", {2'h0, last_read}, 20'h00046);
    endtask
    task automatic t_refresh;
        busy_base = busy_cnt;
        u_dsp_ctrl_model.issue(mk(3'h2, 3'h2, 20'h00000));
        wait_idle();
        check("refresh length", 20'(busy_cnt - busy_base), 20'h00003);
    endtask
    // Sixteen beats fit with nothing draining; the next one is lost
    task automatic t_overflow;
        for (int i = 0; i < 17; i++) begin
            u_dsp_ctrl_model.send_beat({1'b0, 18'h15555});
            if (i == 15) begin
                check("no overrun", {19'h0, write_overrun}, 20'h0);
            end
        end
        repeat (4) @(posedge mclk);
        check("overrun", {19'h0, write_overrun}, 20'h00001);
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1 reset_n = 1'b1;
        t_deselect();
        for (int c = 0; c < 3; c++) begin
            t_burst(2'(c));
        end
        t_masked();
        t_refresh();
        t_overflow();
        report_and_stop();
    end
endmodule
